// File: asc_map.svh
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// ****************************************************************
// Pin timing and widths of the external memory.
// ****************************************************************
`define ASC_CLK_PERIOD_NS  4
`define ASC_T_ACCESS_NS    45
`define ASC_ACC_CYC        ((`ASC_T_ACCESS_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_SYNC_CYC       2
`define ASC_WORD_ADDR_W    19
`define ASC_DATA_W         16
`define ASC_CNT_W          8
`define ASC_LANE_LO        0
`define ASC_LANE_HI        1
`define ASC_LANES_OFF      2'h3
`define ASC_LANES_ON       2'h0
`define ASC_OE_ALL         16'hFFFF
`define ASC_OE_LOW_BYTE    16'h00FF
`define ASC_OE_NONE        16'h0000
`define ASC_WR_LEN         8'(`ASC_ACC_CYC - 1)
`define ASC_RD_LEN         8'(`ASC_ACC_CYC + `ASC_SYNC_CYC - 1)

`endif

// File: asc_pkg.sv
`default_nettype none

package asc_pkg;

    typedef enum logic [4:0] {
        ASC_IDLE   = 5'h01,
        ASC_SETUP  = 5'h02,
        ASC_WR_STB = 5'h04,
        ASC_RD_STB = 5'h08,
        ASC_HOLD   = 5'h10
    } asc_state_e;

    typedef logic [7:0] asc_cnt_t;

endpackage : asc_pkg

`default_nettype wire

// File: asc_tmr_if.sv
`default_nettype none

interface asc_tmr_if;
    logic              load;
    asc_pkg::asc_cnt_t len;
    logic              done;

    modport ctl (output load, output len, input done);
    modport cnt (input load, input len, output done);
endinterface : asc_tmr_if

`default_nettype wire

// File: asc_wait_cnt.sv
`include "asc_map.svh"
`default_nettype none

// Counts a strobe width down; done is high once the count reaches zero.
module asc_wait_cnt (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // Timer port
    asc_tmr_if.cnt    tmr
);
    asc_pkg::asc_cnt_t cnt_ff;
    asc_pkg::asc_cnt_t nxt_cnt;

    always_comb begin
        if (tmr.load) begin
            nxt_cnt = tmr.len;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 8'h01;
        end else begin
            nxt_cnt = cnt_ff;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign tmr.done = (cnt_ff == '0) && !tmr.load;
endmodule : asc_wait_cnt

`default_nettype wire

// File: asc_sram_host.sv
`include "asc_map.svh"
`default_nettype none

// Contract
// - A write takes primary select low, secondary select high and write strobe low together.
// - A read takes both selects active and output strobe low with write strobe held high.
// - The width strap is held high to use the memory in 16-bit word mode.
// - In byte mode one pin is the top address bit and lanes and data bits 14 to 8 are undriven.
module asc_sram_host (
    // Clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           resetn,
    // Configuration, held steady while running
    input  wire logic                           cfg_narrow,
    // Request port
    input  wire logic                           req_valid,
    input  wire logic                           req_write,
    input  wire logic [`ASC_WORD_ADDR_W:0]      req_addr,
    input  wire logic [`ASC_DATA_W-1:0]         req_wdata,
    input  wire logic [1:0]                     req_lane_en,
    output logic                                req_ready,
    // Answer port
    output logic                                resp_valid,
    output logic [`ASC_DATA_W-1:0]              resp_rdata,
    // Memory pins
    output logic                                primary_select_n,
    output logic                                secondary_select,
    output logic                                write_strobe_n,
    output logic                                output_strobe_n,
    output logic                                width_strap,
    output logic [`ASC_WORD_ADDR_W-1:0]         mem_addr,
    output logic                                top_address_bit_narrow_mode,
    output logic                                top_address_oe,
    output logic                                upper_lane_n,
    output logic                                lower_lane_n,
    output logic                                lane_oe,
    output logic [`ASC_DATA_W-1:0]              dq_out,
    output logic [`ASC_DATA_W-1:0]              dq_oe,
    input  wire logic [`ASC_DATA_W-1:0]         dq_in
);
    localparam int C_WR_TAIL = `ASC_ACC_CYC - 7;
    localparam int C_RD = `ASC_ACC_CYC + `ASC_SYNC_CYC;

    // ****************************************************************
    // State.
    // ****************************************************************
    asc_pkg::asc_state_e            state_ff, nxt_state;
    logic                           narrow_ff, nxt_narrow;
    logic                           wide_ff, nxt_wide;
    logic                           strap_done_ff, nxt_strap_done;
    logic                           ready_ff, nxt_ready;
    logic                           rvalid_ff, nxt_rvalid;
    logic [`ASC_DATA_W-1:0]         rdata_ff, nxt_rdata;
    logic                           csn_ff, nxt_csn;
    logic                           sec_ff, nxt_sec;
    logic                           wen_ff, nxt_wen;
    logic                           oen_ff, nxt_oen;
    logic                           is_wr_ff, nxt_is_wr;
    logic [`ASC_WORD_ADDR_W-1:0]    addr_ff, nxt_addr;
    logic                           top_ff, nxt_top;
    logic [1:0]                     lane_n_ff, nxt_lane_n;
    logic [`ASC_DATA_W-1:0]         dq_ff, nxt_dq;
    logic [`ASC_DATA_W-1:0]         dq_oe_ff, nxt_dq_oe;
    logic [`ASC_DATA_W-1:0]         dq_meta_ff, dq_sync_ff;

    asc_tmr_if tmr ();

    asc_wait_cnt u_wait (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tmr      (tmr)
    );

    // ****************************************************************
    // Data pin synchroniser.
    // ****************************************************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dq_meta_ff <= '0;
            dq_sync_ff <= '0;
        end else begin
            dq_meta_ff <= dq_in;
            dq_sync_ff <= dq_meta_ff;
        end
    end

    // ****************************************************************
    // Transfer sequencer.
    // ****************************************************************
    always_comb begin
        nxt_state      = state_ff;
        nxt_narrow     = narrow_ff;
        nxt_strap_done = 1'b1;
        nxt_ready      = ready_ff;
        nxt_rvalid     = 1'b0;
        nxt_rdata      = rdata_ff;
        nxt_csn        = csn_ff;
        nxt_wen        = wen_ff;
        nxt_oen        = oen_ff;
        nxt_is_wr      = is_wr_ff;
        nxt_addr       = addr_ff;
        nxt_top        = top_ff;
        nxt_lane_n     = lane_n_ff;
        nxt_dq         = dq_ff;
        nxt_dq_oe      = dq_oe_ff;
        tmr.load       = 1'b0;
        tmr.len        = '0;
        // The strap is caught once after reset; the memory reads it only at power-up.
        if (!strap_done_ff) begin
            nxt_narrow = cfg_narrow;
            nxt_ready  = 1'b1;
        end
        unique case (state_ff)
            asc_pkg::ASC_IDLE: begin
                if (req_valid && ready_ff) begin
                    nxt_state = asc_pkg::ASC_SETUP;
                    nxt_ready = 1'b0;
                    nxt_csn   = 1'b0;
                    nxt_is_wr = req_write;
                    nxt_addr  = req_addr[`ASC_WORD_ADDR_W-1:0];
                    nxt_top   = req_addr[`ASC_WORD_ADDR_W];
                    nxt_lane_n = narrow_ff ? `ASC_LANES_OFF : ~req_lane_en;
                    nxt_dq    = req_wdata;
                    if (!req_write) begin
                        nxt_dq_oe = `ASC_OE_NONE;
                    end else if (narrow_ff) begin
                        nxt_dq_oe = `ASC_OE_LOW_BYTE;
                    end else begin
                        nxt_dq_oe = `ASC_OE_ALL;
                    end
                end
            end
            asc_pkg::ASC_SETUP: begin
                tmr.load = 1'b1;
                if (is_wr_ff) begin
                    nxt_wen   = 1'b0;
                    tmr.len   = `ASC_WR_LEN;
                    nxt_state = asc_pkg::ASC_WR_STB;
                end else begin
                    nxt_oen   = 1'b0;
                    tmr.len   = `ASC_RD_LEN;
                    nxt_state = asc_pkg::ASC_RD_STB;
                end
            end
            asc_pkg::ASC_WR_STB: begin
                if (tmr.done) begin
                    nxt_wen   = 1'b1;
                    nxt_state = asc_pkg::ASC_HOLD;
                end
            end
            asc_pkg::ASC_RD_STB: begin
                if (tmr.done) begin
                    nxt_oen    = 1'b1;
                    nxt_rvalid = 1'b1;
                    nxt_rdata  = narrow_ff ? {8'h00, dq_sync_ff[7:0]} : dq_sync_ff;
                    nxt_state  = asc_pkg::ASC_HOLD;
                end
            end
            asc_pkg::ASC_HOLD: begin
                // Data stays driven one cycle past the strobe to meet hold.
                nxt_csn    = 1'b1;
                nxt_dq_oe  = `ASC_OE_NONE;
                nxt_lane_n = `ASC_LANES_OFF;
                nxt_ready  = 1'b1;
                nxt_state  = asc_pkg::ASC_IDLE;
            end
        endcase
        nxt_sec  = !nxt_csn;
        nxt_wide = !nxt_narrow;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff      <= asc_pkg::ASC_IDLE;
            narrow_ff     <= 1'b0;
            wide_ff       <= 1'b1;
            strap_done_ff <= 1'b0;
            ready_ff      <= 1'b0;
            rvalid_ff     <= 1'b0;
            rdata_ff      <= '0;
            csn_ff        <= 1'b1;
            sec_ff        <= 1'b0;
            wen_ff        <= 1'b1;
            oen_ff        <= 1'b1;
            is_wr_ff      <= 1'b0;
            addr_ff       <= '0;
            top_ff        <= 1'b0;
            lane_n_ff     <= `ASC_LANES_OFF;
            dq_ff         <= '0;
            dq_oe_ff      <= `ASC_OE_NONE;
        end else begin
            state_ff      <= nxt_state;
            narrow_ff     <= nxt_narrow;
            wide_ff       <= nxt_wide;
            strap_done_ff <= nxt_strap_done;
            ready_ff      <= nxt_ready;
            rvalid_ff     <= nxt_rvalid;
            rdata_ff      <= nxt_rdata;
            csn_ff        <= nxt_csn;
            sec_ff        <= nxt_sec;
            wen_ff        <= nxt_wen;
            oen_ff        <= nxt_oen;
            is_wr_ff      <= nxt_is_wr;
            addr_ff       <= nxt_addr;
            top_ff        <= nxt_top;
            lane_n_ff     <= nxt_lane_n;
            dq_ff         <= nxt_dq;
            dq_oe_ff      <= nxt_dq_oe;
        end
    end

    // ****************************************************************
    // Pin outputs.
    // ****************************************************************
    assign req_ready                   = ready_ff;
    assign resp_valid                  = rvalid_ff;
    assign resp_rdata                  = rdata_ff;
    assign primary_select_n            = csn_ff;
    assign secondary_select            = sec_ff;
    assign write_strobe_n              = wen_ff;
    assign output_strobe_n             = oen_ff;
    assign width_strap                 = wide_ff;
    assign mem_addr                    = addr_ff;
    assign top_address_bit_narrow_mode = top_ff;
    assign top_address_oe              = narrow_ff;
    assign upper_lane_n                = lane_n_ff[`ASC_LANE_HI];
    assign lower_lane_n                = lane_n_ff[`ASC_LANE_LO];
    assign lane_oe                     = wide_ff;
    assign dq_out                      = dq_ff;
    assign dq_oe                       = dq_oe_ff;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_wr_low;
        !write_strobe_n && !primary_select_n && secondary_select;
    endsequence

    property p_wr_sel;
        !write_strobe_n |-> !primary_select_n && secondary_select && output_strobe_n;
    endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("write strobe without select");
    property p_wr_len;
        $fell(write_strobe_n) |-> s_wr_low [*8] ##[C_WR_TAIL:C_WR_TAIL] $rose(write_strobe_n);
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe width wrong");

    property p_rd_sel;
        !output_strobe_n |-> write_strobe_n && !primary_select_n && secondary_select;
    endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("read strobe without select");

    property p_rd_resp;
        $fell(output_strobe_n) |-> ##[C_RD:C_RD] resp_valid;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read answer late");

    property p_no_fight;
        !output_strobe_n |-> dq_oe == `ASC_OE_NONE;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("data driven during read");

    property p_strap;
        strap_done_ff && $stable(narrow_ff) |-> width_strap == !narrow_ff;
    endproperty
    a_strap: assert property (p_strap) else $error("width strap wrong");

    property p_narrow_pins;
        narrow_ff |-> !lane_oe && (dq_oe[14:8] == 7'h00) && top_address_oe;
    endproperty
    a_narrow_pins: assert property (p_narrow_pins) else $error("byte mode pin driven");

    property p_hold;
        $rose(write_strobe_n) |-> !primary_select_n && (dq_oe != `ASC_OE_NONE || !is_wr_ff)
            ##1 primary_select_n;
    endproperty
    a_hold: assert property (p_hold) else $error("write hold cycle missing");
endmodule : asc_sram_host

`default_nettype wire

// File: asc_sram_model.sv
`default_nettype none

// Behavioural external memory; data appears only after the access delay.
module asc_sram_model #(
    parameter int ACC_NS     = 45,
    parameter bit SINGLE_SEL = 1'b0
) (
    // Memory pins
    input  wire logic        primary_select_n,
    input  wire logic        secondary_select,
    input  wire logic        write_strobe_n,
    input  wire logic        output_strobe_n,
    input  wire logic        width_strap,
    input  wire logic [18:0] mem_addr,
    input  wire logic        top_address_bit_narrow_mode,
    input  wire logic        upper_lane_n,
    input  wire logic        lower_lane_n,
    input  wire logic [15:0] dq,
    // Memory drive
    output logic [15:0]      dq_drv,
    output logic [15:0]      dq_drv_oe,
    output logic             standby
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem_q [int];
    logic       sel;
    logic       narrow;
    logic       rd_on;
    logic       data_ok = 1'b0;
    int         lo_key;

    function automatic logic [7:0] rd_byte(input int k);
        return mem_q.exists(k) ? mem_q[k] : 8'hA5;
    endfunction : rd_byte

    assign sel     = SINGLE_SEL ? !primary_select_n : (!primary_select_n && secondary_select);
    assign narrow  = !width_strap;
    assign standby = !sel || (!narrow && upper_lane_n && lower_lane_n);
    assign lo_key  = narrow ? int'({top_address_bit_narrow_mode, mem_addr}) : int'({mem_addr, 1'b0});

    always @(posedge write_strobe_n) begin
        if (sel && narrow) begin
            mem_q[lo_key] = dq[7:0];
        end else if (sel) begin
            if (!lower_lane_n) mem_q[lo_key] = dq[7:0];
            if (!upper_lane_n) mem_q[lo_key + 1] = dq[15:8];
        end
    end

    // Data is not valid until the full access time has passed.
    always @(negedge output_strobe_n) begin
        data_ok = 1'b0;
        #(ACC_NS);
        data_ok = !output_strobe_n;
    end
    always @(posedge output_strobe_n) data_ok = 1'b0;

    assign rd_on = sel && data_ok && !output_strobe_n && write_strobe_n;
    always @* begin
        dq_drv    = {rd_byte(lo_key + 1), rd_byte(lo_key)};
        dq_drv_oe = 16'h0000;
        if (rd_on && narrow) dq_drv_oe = 16'h00FF;
        else if (rd_on) dq_drv_oe = {{8{!upper_lane_n}}, {8{!lower_lane_n}}};
    end
endmodule : asc_sram_model

`default_nettype wire

// File: asc_sram_host_bench.sv
`default_nettype none

module asc_sram_host_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk, resetn, cfg_narrow, req_valid, req_write, req_ready, resp_valid;
    logic [19:0] req_addr;
    logic [15:0] req_wdata, resp_rdata, dq_out, dq_oe, dq_bus, dq_drv, dq_drv_oe;
    logic [18:0] mem_addr;
    logic [1:0]  req_lane_en;
    logic pri_n, sec, we_n, oe_n, strap, top_bit, top_oe, up_n, lo_n, lane_oe, standby, live;
    logic [15:0] float_ff = 16'h5AC3;
    int          num_errors = 0;
    int          checked = 0;

    asc_sram_host dut_u (.core_clk(core_clk), .resetn(resetn), .cfg_narrow(cfg_narrow),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_lane_en(req_lane_en), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_rdata(resp_rdata), .primary_select_n(pri_n),
        .secondary_select(sec), .write_strobe_n(we_n), .output_strobe_n(oe_n),
        .width_strap(strap), .mem_addr(mem_addr), .top_address_bit_narrow_mode(top_bit),
        .top_address_oe(top_oe), .upper_lane_n(up_n), .lower_lane_n(lo_n),
        .lane_oe(lane_oe), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_bus));

    asc_sram_model mem_u (.primary_select_n(pri_n), .secondary_select(sec),
        .write_strobe_n(we_n), .output_strobe_n(oe_n), .width_strap(strap),
        .mem_addr(mem_addr), .top_address_bit_narrow_mode(top_bit), .upper_lane_n(up_n),
        .lower_lane_n(lo_n), .dq(dq_bus), .dq_drv(dq_drv), .dq_drv_oe(dq_drv_oe),
        .standby(standby));

    // A released bus wanders, so stale data can never look correct.
    assign dq_bus = (dq_oe & dq_out) | (dq_drv_oe & dq_drv) | (~(dq_oe | dq_drv_oe) & float_ff);
    always @(posedge core_clk) float_ff <= ~float_ff;

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    always @(negedge core_clk) begin
        if (live) begin
            if (!we_n) check(20'({pri_n, sec, oe_n}), 20'h00003);
            if (!oe_n) check(20'({pri_n, sec, we_n}), 20'h00003);
            check(20'(strap), 20'(!cfg_narrow));
            if (cfg_narrow) check(20'({lane_oe, top_oe, dq_oe[15:8]}), 20'h00100);
            check(20'(dq_oe & dq_drv_oe), 20'h00000);
        end
    end

    task automatic do_reset(input logic narrow);
        @(posedge core_clk);
        resetn <= 1'b0;
        live <= 1'b0;
        cfg_narrow <= narrow;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        live <= 1'b1;
    endtask : do_reset

    task automatic access(input logic wr, input logic [19:0] addr, input logic [15:0] wd,
                          input logic [1:0] lanes, output logic [15:0] rd);
        int n;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= addr;
        req_wdata <= wd;
        req_lane_en <= lanes;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        req_valid <= 1'b0;
        n = (n >= 40) ? 99 : 0;
        while (!wr && resp_valid !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        rd = resp_rdata;
        if (n >= 40) begin
            num_errors++;
            complete_run();
        end
    endtask : access

    task automatic t_word_lanes();
        logic [15:0] rd;
        access(1'b1, 20'h7FFFF, 16'hC3A5, 2'b11, rd);
        access(1'b0, 20'h7FFFF, 16'h0000, 2'b11, rd);
        check(20'(rd), 20'h0C3A5);
        access(1'b1, 20'h7FFFF, 16'h1E77, 2'b01, rd);
        access(1'b0, 20'h7FFFF, 16'h0000, 2'b11, rd);
        check(20'(rd), 20'h0C377);
        access(1'b1, 20'h7FFFF, 16'h9B2D, 2'b10, rd);
        access(1'b0, 20'h7FFFF, 16'h0000, 2'b11, rd);
        check(20'(rd), 20'h09B77);
        access(1'b1, 20'h7FFFF, 16'h4444, 2'b00, rd);
        access(1'b0, 20'h7FFFF, 16'h0000, 2'b11, rd);
        check(20'(rd), 20'h09B77);
        access(1'b0, 20'h7FFFF, 16'h0000, 2'b01, rd);
        check(20'(rd[7:0]), 20'h00077);
        access(1'b0, 20'h7FFFF, 16'h0000, 2'b10, rd);
        check(20'(rd[15:8]), 20'h0009B);
        repeat (3) @(posedge core_clk);
        check(20'(standby), 20'h00001);
        $display("test word lanes done");
    endtask : t_word_lanes

    task automatic t_adjacent();
        logic [15:0] rd;
        access(1'b1, 20'h00000, 16'h0F1E, 2'b11, rd);
        access(1'b1, 20'h00001, 16'hE1F0, 2'b11, rd);
        access(1'b0, 20'h00000, 16'h0000, 2'b11, rd);
        check(20'(rd), 20'h00F1E);
        access(1'b0, 20'h00001, 16'h0000, 2'b11, rd);
        check(20'(rd), 20'h0E1F0);
        $display("test adjacent words done");
    endtask : t_adjacent

    task automatic t_narrow();
        logic [15:0] rd;
        do_reset(1'b1);
        access(1'b1, 20'h80005, 16'hFF3C, 2'b00, rd);
        access(1'b1, 20'h00005, 16'hFFD2, 2'b00, rd);
        access(1'b0, 20'h80005, 16'h0000, 2'b00, rd);
        check(20'(rd), 20'h0003C);
        access(1'b0, 20'h00005, 16'h0000, 2'b00, rd);
        check(20'(rd), 20'h000D2);
        $display("test byte mode done");
    endtask : t_narrow

    initial begin
        resetn = 1'b0;
        cfg_narrow = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 20'h00000;
        req_wdata = 16'h0000;
        req_lane_en = 2'h0;
        live = 1'b0;
        do_reset(1'b0);
        t_word_lanes();
        t_adjacent();
        t_narrow();
        complete_run();
    end
endmodule : asc_sram_host_bench

`default_nettype wire
